// ---- hw/psl_pkg.sv ----
// Constants, types and register map of the power-state and indicator controller
package psl_pkg;
    // System clock rate
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned MS_PER_S = 1000;
    // Time figures in their own units
    localparam logic [8:0] WL_TIMEOUT_S = 9'h12C;    // 300 s, i.e. 5 minutes
    localparam logic [8:0] TS_TIMEOUT_S = 9'h01E;    // 30 s
    localparam logic [19:0] WAKE_LEAD_S = 20'h0000F; // 15 s
    localparam int unsigned DEB_MS_DEF = 20;         // Switch debounce time
    // Millisecond phase of the LED patterns
    localparam logic [13:0] PHASE_WRAP_MS = 14'h270F; // 10 s frame
    localparam logic [13:0] BLUE_PER_MS = 14'h01F4;   // 2 Hz
    localparam logic [13:0] BLUE_ON_MS = 14'h00FA;
    localparam logic [13:0] RED_PER_MS = 14'h03E8;    // 1 Hz
    localparam logic [13:0] RED_ON_MS = 14'h01F4;
    localparam logic [13:0] RED_FLASH_MS = 14'h0064;  // 0.1 s flash width
    localparam logic [9:0] SEC_WRAP_MS = 10'h3E7;
    localparam logic [15:0] RT_INT_DEF = 16'h01F4;    // 500 ms, 2 Hz
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RT_INT = 8'h04;
    localparam logic [7:0] ADDR_SCHED = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
    localparam logic [7:0] ADDR_IRQ_CLR = 8'h18;
    // Control fields
    localparam int unsigned CTRL_LOG_EN = 0;
    localparam int unsigned CTRL_MODE_LO = 1;
    localparam int unsigned CTRL_MODE_HI = 2;
    localparam int unsigned CTRL_WL_REQ = 3;
    // Interrupt bits
    localparam int unsigned IRQ_WAKE = 0;
    localparam int unsigned IRQ_SLEEP = 1;
    localparam int unsigned IRQ_MAG = 2;
    localparam int unsigned IRQ_FAULT = 3;
    localparam int unsigned IRQ_LOG = 4;
    localparam int unsigned IRQ_W = 5;
    // Power states; Off is simply no supply, i.e. held in reset
    typedef enum logic {PWR_ASLEEP = 1'b0, PWR_AWAKE = 1'b1} psl_pwr_e;
    // Awake logging modes
    typedef enum logic [1:0] {
        MODE_INACTIVE = 2'b00,
        MODE_REALTIME = 2'b01,
        MODE_SAMPLE_HOLD = 2'b10
    } psl_mode_e;
    // Status word, high bit first
    typedef struct packed {
        logic log_pending;
        logic fault;
        logic linked;
        logic wl_en;
        logic awake;
    } psl_stat_s;
    // Indicator pair
    typedef struct packed {
        logic red;
        logic blue;
    } psl_led_s;
endpackage : psl_pkg

// ---- hw/psl_ctrl.sv ----
// Power-state sequencer, wake timers, LED codes and logging modes
//
// Functional notes
// - Always exactly one of Off, Asleep, Awake
// - Asleep holds until command or schedule due
// - Awake timers: wireless 5 min, topside 30 s
// - Both timers expired: wireless off, sleep
// - Scheduled logging wakes 15 s early
// - Wake on magnet, power cycle, topside, sensor
// - Magnet swipe enables wireless link
// - Power cycle or host request enables wireless
// - Blue dark while wireless disabled
// - Blue solid when enabled, not linked
// - Blue blinks 2 Hz when linked
// - Red dark when Off or idle Asleep
// - Red flashes every 10 s asleep logging
// - Red blinks 1 Hz awake without faults
// - Red solid when awake with faults
// - Awake modes: inactive, real-time, sample/hold
`timescale 1ns/1ps
`default_nettype none
module psl_ctrl #(
    parameter int unsigned MS_CYCLES = psl_pkg::CLK_HZ / psl_pkg::MS_PER_S,
    parameter int unsigned DEB_MS = psl_pkg::DEB_MS_DEF,
    parameter logic [9:0] SEC_WRAP = psl_pkg::SEC_WRAP_MS
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mag_sw,
    input wire logic topside_act,
    input wire logic wireless_act,
    input wire logic wl_linked,
    input wire logic sensor_insert,
    input wire logic fault,
    input wire logic sh_sync,
    output logic power_awake,
    output logic wl_enable,
    output psl_pkg::psl_led_s leds,
    output logic log_strobe,
    output logic irq
);
    import psl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Time base
    logic [31:0] ms_cnt, next_ms_cnt;   // Cycles within a millisecond
    logic [9:0] sec_ms, next_sec_ms;    // Milliseconds within a second
    logic [13:0] phase, next_phase;     // LED pattern phase
    logic ms_tick;
    logic sec_tick;

    // Millisecond and second strobes
    always_comb begin
        ms_tick = (ms_cnt == 32'(MS_CYCLES - 1));
        sec_tick = ms_tick && (sec_ms == SEC_WRAP);
        next_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt + 32'h0000_0001;
        next_sec_ms = sec_ms;
        next_phase = phase;
        if (ms_tick) begin
            next_sec_ms = sec_tick ? 10'h000 : sec_ms + 10'h001;
            next_phase = (phase == PHASE_WRAP_MS) ? 14'h0000 : phase + 14'h0001;
        end
    end

    // Time base registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ms_cnt <= 32'h0000_0000;
            sec_ms <= 10'h000;
            phase <= 14'h0000;
        end else begin
            ms_cnt <= next_ms_cnt;
            sec_ms <= next_sec_ms;
            phase <= next_phase;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Magnetic switch qualification
    logic mag_s1, mag_s2;               // Synchroniser pair
    logic mag_q, next_mag_q;            // Debounced level
    logic [15:0] deb_cnt, next_deb_cnt; // Stable-time counter
    logic mag_evt, next_mag_evt;        // One pulse per swipe

    // A level must hold DEB_MS before it counts; bounces restart the wait
    always_comb begin
        next_mag_q = mag_q;
        next_deb_cnt = deb_cnt;
        if (mag_s2 == mag_q) begin
            next_deb_cnt = 16'h0000;
        end else if (ms_tick) begin
            if (deb_cnt == 16'(DEB_MS - 1)) begin
                next_mag_q = mag_s2;
                next_deb_cnt = 16'h0000;
            end else begin
                next_deb_cnt = deb_cnt + 16'h0001;
            end
        end
        next_mag_evt = next_mag_q && !mag_q;
    end

    // Switch registers; first stage read only by the second
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            mag_s1 <= 1'b0;
            mag_s2 <= 1'b0;
            mag_q <= 1'b0;
            deb_cnt <= 16'h0000;
            mag_evt <= 1'b0;
        end else begin
            mag_s1 <= mag_sw;
            mag_s2 <= mag_s1;
            mag_q <= next_mag_q;
            deb_cnt <= next_deb_cnt;
            mag_evt <= next_mag_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus decode
    logic log_en, next_log_en;           // Scheduled logging enabled
    logic [1:0] mode, next_mode;         // Awake logging mode
    logic [15:0] rt_int, next_rt_int;    // Real-time interval, ms
    logic [IRQ_W-1:0] irq_en, next_irq_en;
    logic [IRQ_W-1:0] irq_stat, next_irq_stat;
    logic [IRQ_W-1:0] irq_set;
    logic [31:0] next_prdata;
    logic wr_acc;
    logic addr_hit;
    logic wl_req;
    psl_stat_s stat;

    // Zero-wait slave; unknown offsets answer with an error
    always_comb begin
        wr_acc = psel && penable && pwrite;
        addr_hit = (paddr == ADDR_CTRL) || (paddr == ADDR_RT_INT) || (paddr == ADDR_SCHED)
                || (paddr == ADDR_STATUS) || (paddr == ADDR_IRQ_STAT)
                || (paddr == ADDR_IRQ_EN) || (paddr == ADDR_IRQ_CLR);
        pready = 1'b1;
        pslverr = psel && penable && !addr_hit;
        wl_req = wr_acc && (paddr == ADDR_CTRL) && pwdata[CTRL_WL_REQ];
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state and wake timers
    psl_pwr_e pwr, next_pwr;
    logic wl_en, next_wl_en;
    logic [8:0] wl_tmr, next_wl_tmr;    // Seconds left on wireless
    logic [8:0] ts_tmr, next_ts_tmr;    // Seconds left on topside
    logic [19:0] sched, next_sched;     // Seconds to next scheduled log
    logic sched_wake;
    logic wake_evt;
    logic wl_evt;

    // Wake sources and the sleep decision
    always_comb begin
        sched_wake = log_en && (sched != 20'h00000) && (sched <= WAKE_LEAD_S);
        wake_evt = mag_evt || topside_act || sensor_insert || sched_wake;
        wl_evt = mag_evt || wl_req;
        next_pwr = pwr;
        next_wl_en = wl_en;
        next_wl_tmr = wl_tmr;
        next_ts_tmr = ts_tmr;
        // Timers run only while awake
        if (pwr == PWR_AWAKE && sec_tick) begin
            if (wl_tmr != 9'h000) next_wl_tmr = wl_tmr - 9'h001;
            if (ts_tmr != 9'h000) next_ts_tmr = ts_tmr - 9'h001;
        end
        unique case (pwr)
            PWR_ASLEEP: begin
                // A swipe, topside or sensor activity, a host request or the schedule leaves sleep
                if (wake_evt || wl_req) begin
                    next_pwr = PWR_AWAKE;
                    next_ts_tmr = TS_TIMEOUT_S;
                end
            end
            PWR_AWAKE: begin
                if (topside_act || sensor_insert || sched_wake) begin
                    next_ts_tmr = TS_TIMEOUT_S;
                end
                if (wireless_act && wl_en) begin
                    next_wl_tmr = WL_TIMEOUT_S;
                end
                if (wl_tmr == 9'h000 && ts_tmr == 9'h000 && !wake_evt && !wl_evt) begin
                    next_pwr = PWR_ASLEEP;
                    next_wl_en = 1'b0;
                end
            end
        endcase
        // Enabling the link restarts its inactivity window
        if (wl_evt) begin
            next_wl_en = 1'b1;
            next_wl_tmr = WL_TIMEOUT_S;
        end
    end

    // Power-up counts as a power cycle: awake, link enabled
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            pwr <= PWR_AWAKE;
            wl_en <= 1'b1;
            wl_tmr <= WL_TIMEOUT_S;
            ts_tmr <= TS_TIMEOUT_S;
        end else begin
            pwr <= next_pwr;
            wl_en <= next_wl_en;
            wl_tmr <= next_wl_tmr;
            ts_tmr <= next_ts_tmr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Logging strobes
    logic [15:0] rt_cnt, next_rt_cnt;
    logic next_log_strobe;
    logic sched_hit;

    // Real-time interval, external sync, or schedule reaching zero
    always_comb begin
        next_sched = sched;
        sched_hit = 1'b0;
        if (wr_acc && paddr == ADDR_SCHED) begin
            next_sched = pwdata[19:0];
        end else if (sec_tick && sched != 20'h00000) begin
            next_sched = sched - 20'h00001;
            sched_hit = log_en && (sched == 20'h00001);
        end
        next_rt_cnt = rt_cnt;
        next_log_strobe = sched_hit;
        if (pwr == PWR_AWAKE && mode == MODE_REALTIME) begin
            if (ms_tick) begin
                if (rt_cnt + 16'h0001 >= rt_int) begin
                    next_rt_cnt = 16'h0000;
                    next_log_strobe = 1'b1;
                end else begin
                    next_rt_cnt = rt_cnt + 16'h0001;
                end
            end
        end else begin
            next_rt_cnt = 16'h0000;
        end
        if (pwr == PWR_AWAKE && mode == MODE_SAMPLE_HOLD && sh_sync) begin
            next_log_strobe = 1'b1;
        end
    end

    // Logging registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sched <= 20'h00000;
            rt_cnt <= 16'h0000;
            log_strobe <= 1'b0;
        end else begin
            sched <= next_sched;
            rt_cnt <= next_rt_cnt;
            log_strobe <= next_log_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software registers and interrupts
    logic fault_d;

    // Writes, read mux, sticky status; a set beats a clear
    always_comb begin
        next_log_en = log_en;
        next_mode = mode;
        next_rt_int = rt_int;
        next_irq_en = irq_en;
        if (wr_acc && paddr == ADDR_CTRL) begin
            next_log_en = pwdata[CTRL_LOG_EN];
            next_mode = pwdata[CTRL_MODE_HI:CTRL_MODE_LO];
        end
        if (wr_acc && paddr == ADDR_RT_INT) next_rt_int = pwdata[15:0];
        if (wr_acc && paddr == ADDR_IRQ_EN) next_irq_en = pwdata[IRQ_W-1:0];
        irq_set = '0;
        irq_set[IRQ_WAKE] = (pwr == PWR_ASLEEP) && (next_pwr == PWR_AWAKE);
        irq_set[IRQ_SLEEP] = (pwr == PWR_AWAKE) && (next_pwr == PWR_ASLEEP);
        irq_set[IRQ_MAG] = mag_evt;
        irq_set[IRQ_FAULT] = fault && !fault_d;
        irq_set[IRQ_LOG] = next_log_strobe;
        next_irq_stat = irq_stat;
        if (wr_acc && paddr == ADDR_IRQ_CLR) next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
        next_irq_stat = next_irq_stat | irq_set;
        stat.awake = (pwr == PWR_AWAKE);
        stat.wl_en = wl_en;
        stat.linked = wl_linked;
        stat.fault = fault;
        stat.log_pending = (sched != 20'h00000);
        // Read data latched in the setup phase
        next_prdata = prdata;
        if (psel && !penable) begin
            unique case (paddr)
                ADDR_CTRL: next_prdata = {28'h0000000, 1'b0, mode, log_en};
                ADDR_RT_INT: next_prdata = {16'h0000, rt_int};
                ADDR_SCHED: next_prdata = {12'h000, sched};
                ADDR_STATUS: next_prdata = {27'h0000000, stat};
                ADDR_IRQ_STAT: next_prdata = {27'h0000000, irq_stat};
                ADDR_IRQ_EN: next_prdata = {27'h0000000, irq_en};
                default: next_prdata = 32'h0000_0000;
            endcase
        end
    end

    // Register file
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            log_en <= 1'b0;
            mode <= MODE_INACTIVE;
            rt_int <= RT_INT_DEF;
            irq_en <= '0;
            irq_stat <= '0;
            fault_d <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            log_en <= next_log_en;
            mode <= next_mode;
            rt_int <= next_rt_int;
            irq_en <= next_irq_en;
            irq_stat <= next_irq_stat;
            fault_d <= fault;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Indicators
    psl_led_s next_leds;

    // Blink codes from the shared 10 s phase
    always_comb begin
        next_leds.blue = 1'b0;
        if (wl_en) begin
            if (!wl_linked) next_leds.blue = 1'b1;
            else next_leds.blue = (phase % BLUE_PER_MS) < BLUE_ON_MS;
        end
        next_leds.red = 1'b0;
        if (pwr == PWR_AWAKE) begin
            if (fault) next_leds.red = 1'b1;
            else next_leds.red = (phase % RED_PER_MS) < RED_ON_MS;
        end else if (log_en) begin
            next_leds.red = phase < RED_FLASH_MS;
        end
    end

    // Outputs from flip-flops
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            leds <= '0;
        end else begin
            leds <= next_leds;
        end
    end

    // Supply control and interrupt line
    always_comb begin
        power_awake = (pwr == PWR_AWAKE);
        wl_enable = wl_en;
        irq = |(irq_stat & irq_en);
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_sleep_on_idle: assert property (@(posedge mclk) disable iff (!resetn)
        (pwr == PWR_AWAKE && wl_tmr == 9'h000 && ts_tmr == 9'h000 && !wake_evt && !wl_evt)
        |=> (pwr == PWR_ASLEEP && !wl_en)) else $error("idle awake did not sleep");
    a_mag_wakes: assert property (@(posedge mclk) disable iff (!resetn)
        mag_evt |=> (pwr == PWR_AWAKE && wl_en && wl_tmr == WL_TIMEOUT_S))
        else $error("swipe did not wake and enable link");
    a_mag_single: assert property (@(posedge mclk) disable iff (!resetn)
        mag_evt |=> !mag_evt) else $error("swipe event longer than a cycle");
    a_ts_reload: assert property (@(posedge mclk) disable iff (!resetn)
        topside_act |=> (pwr == PWR_AWAKE && ts_tmr == TS_TIMEOUT_S))
        else $error("topside activity did not restart timer");
    a_blue_dark: assert property (@(posedge mclk) disable iff (!resetn)
        !wl_en |=> !leds.blue) else $error("blue lit with link disabled");
    a_blue_solid: assert property (@(posedge mclk) disable iff (!resetn)
        (wl_en && !wl_linked) |=> leds.blue) else $error("blue not solid");
    a_red_dark: assert property (@(posedge mclk) disable iff (!resetn)
        (pwr == PWR_ASLEEP && !log_en) |=> !leds.red) else $error("red lit while idle asleep");
    a_red_fault: assert property (@(posedge mclk) disable iff (!resetn)
        (pwr == PWR_AWAKE && fault) |=> leds.red) else $error("red not solid on fault");
    a_sched_wake: assert property (@(posedge mclk) disable iff (!resetn)
        sched_wake |=> pwr == PWR_AWAKE) else $error("schedule lead did not wake");
    a_irq_sticky: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(power_awake) |-> irq_stat[IRQ_WAKE]) else $error("wake not flagged");
endmodule : psl_ctrl
`default_nettype wire

// ---- tb/psl_host_model.sv ----
// Host and magnet stand-in driving the link side of the controller
`timescale 1ns/1ps
`default_nettype none
module psl_host_model (
    input wire logic mclk,
    output logic topside_act,
    output logic wireless_act,
    output logic wl_linked,
    output logic mag_sw
);
    ////////////////////////////////////////////////////////////
    // Idle levels from time zero, magnet away
    initial begin
        topside_act = 1'b0;
        wireless_act = 1'b0;
        wl_linked = 1'b0;
        mag_sw = 1'b0;
    end
    // One topside message, a single-cycle pulse
    task automatic talk_topside();
        @(posedge mclk);
        topside_act <= 1'b1;
        @(posedge mclk);
        topside_act <= 1'b0;
    endtask : talk_topside
    // One wireless message, a single-cycle pulse
    task automatic talk_wireless();
        @(posedge mclk);
        wireless_act <= 1'b1;
        @(posedge mclk);
        wireless_act <= 1'b0;
    endtask : talk_wireless
    // Wireless link up or down
    task automatic set_link(input logic v);
        @(posedge mclk);
        wl_linked <= v;
    endtask : set_link
    // Contact chatter first, so the debouncer must reject short blips
    task automatic mag_on();
        repeat (3) begin
            @(posedge mclk);
            mag_sw <= 1'b1;
            @(posedge mclk);
            mag_sw <= 1'b0;
        end
        @(posedge mclk);
        mag_sw <= 1'b1;
    endtask : mag_on
    // Magnet taken away
    task automatic mag_off();
        @(posedge mclk);
        mag_sw <= 1'b0;
    endtask : mag_off
endmodule : psl_host_model
`default_nettype wire

// ---- tb/sonde_power_state_led_ctrl_test.sv ----
// Self-checking bench for the power-state and indicator controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, got); fail_count++; end end
module sonde_power_state_led_ctrl_test;
    import psl_pkg::*;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic mag_sw, topside_act, wireless_act, wl_linked, sensor_insert, fault, sh_sync;
    logic power_awake, wl_enable, log_strobe, irq, red_led, blue_led;
    psl_led_s leds;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int t0;
    assign red_led = leds.red;
    assign blue_led = leds.blue;
    // One-cycle ms and a 20 ms second keep the 300 s wireless timeout short
    localparam int unsigned SEC_CYC = 20;
    psl_ctrl #(.MS_CYCLES(1), .DEB_MS(2), .SEC_WRAP(10'(SEC_CYC - 1))) DUT (.mclk(mclk), .resetn(resetn),
        .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mag_sw(mag_sw), .topside_act(topside_act), .wireless_act(wireless_act), .wl_linked(wl_linked),
        .sensor_insert(sensor_insert), .fault(fault), .sh_sync(sh_sync), .power_awake(power_awake),
        .wl_enable(wl_enable), .leds(leds), .log_strobe(log_strobe), .irq(irq));
    psl_host_model HOST (.mclk(mclk), .topside_act(topside_act), .wireless_act(wireless_act),
        .wl_linked(wl_linked), .mag_sw(mag_sw));
    ////////////////////////////////////////////////////////////
    // 50 MHz clock and a free cycle count for elapsed times
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) cyc <= cyc + 1;
    // Verdict and end of run
    task automatic test_done();
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // One APB transfer, request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            fail_count++;
            test_done();
        end
    endtask : apb
    // Bounded wait for a level; a hang is a mismatch
    task automatic wait_for(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(negedge mclk);
            n++;
        end
        if (s !== v) begin
            fail_count++;
            test_done();
        end
    endtask : wait_for
    // High cycles over a window, sampled mid-cycle
    task automatic count(ref logic s, input int len, output int c);
        c = 0;
        repeat (len) begin
            @(negedge mclk);
            c += (s === 1'b1) ? 1 : 0;
        end
    endtask : count
    ////////////////////////////////////////////////////////////
    // Power-up state, register defaults, unmapped access
    task automatic t_reset();
        @(negedge mclk);
        `CHK("awake", 1'b1, power_awake)
        `CHK("wl_en", 1'b1, wl_enable)
        apb(1'b0, ADDR_RT_INT, 32'h0);
        `CHK("rt_int", 32'h000001F4, rd)
        apb(1'b0, ADDR_STATUS, 32'h0);
        `CHK("status", 32'h00000003, rd)
        apb(1'b1, 8'h1C, 32'hFFFFFFFF);
        `CHK("slverr", 1'b1, err)
    endtask : t_reset
    // LED codes while awake, a 1000 ms window each
    task automatic t_leds();
        int c;
        repeat (4) @(negedge mclk);
        count(red_led, 1000, c);
        `CHK("red_1hz", 500, c)
        count(blue_led, 1000, c);
        `CHK("blue_solid", 1000, c)
        HOST.set_link(1'b1);
        fault <= 1'b1;
        repeat (4) @(negedge mclk);
        count(red_led, 1000, c);
        `CHK("red_fault", 1000, c)
        count(blue_led, 1000, c);
        `CHK("blue_2hz", 500, c)
        HOST.set_link(1'b0);
        fault <= 1'b0;
    endtask : t_leds
    // Realtime, sample/hold and inactive logging
    task automatic t_modes();
        int c;
        apb(1'b1, ADDR_RT_INT, 32'h0000000A);
        apb(1'b1, ADDR_CTRL, 32'h00000002);
        repeat (30) @(negedge mclk);
        count(log_strobe, 100, c);
        `CHK("realtime", 10, c)
        for (int m = 4; m >= 0; m -= 4) begin
            apb(1'b1, ADDR_CTRL, m);
            @(posedge mclk);
            sh_sync <= 1'b1;
            @(posedge mclk);
            sh_sync <= 1'b0;
            count(log_strobe, 20, c);
            `CHK("sample_hold", (m == 4) ? 1 : 0, c)
        end
    endtask : t_modes
    // Sleep once both timers run out, with its interrupt
    task automatic t_sleep();
        int c;
        apb(1'b1, ADDR_IRQ_CLR, 32'h0000001F);
        apb(1'b1, ADDR_IRQ_EN, 32'h00000002);
        wait_for(power_awake, 1'b0, 400 * SEC_CYC);
        `CHK("wl_time", 1'b1, (cyc - t0 >= 299 * SEC_CYC && cyc - t0 <= 302 * SEC_CYC))
        `CHK("wl_off", 1'b0, wl_enable)
        `CHK("irq_sleep", 1'b1, irq)
        apb(1'b1, ADDR_IRQ_EN, 32'h00000000);
        @(negedge mclk);
        `CHK("irq_mask", 1'b0, irq)
        apb(1'b1, ADDR_IRQ_CLR, 32'h0000001F);
        HOST.talk_wireless();
        count(red_led, 1000, c);
        `CHK("red_dark", 0, c)
        `CHK("stay_asleep", 1'b0, power_awake)
    endtask : t_sleep
    // Scheduled logging: flash while asleep, early wake, log at due time
    task automatic t_sched();
        int c;
        apb(1'b1, ADDR_SCHED, 32'h00000258);
        t0 = cyc;
        apb(1'b1, ADDR_CTRL, 32'h00000001);
        repeat (2) @(negedge mclk);
        count(red_led, 10000, c);
        `CHK("red_flash", 100, c)
        `CHK("asleep_log", 1'b0, power_awake)
        wait_for(power_awake, 1'b1, 150 * SEC_CYC);
        `CHK("lead_15s", 1'b1, (cyc - t0 >= 584 * SEC_CYC && cyc - t0 <= 586 * SEC_CYC))
        wait_for(log_strobe, 1'b1, 30 * SEC_CYC);
        `CHK("log_due", 1'b1, (cyc - t0 >= 599 * SEC_CYC && cyc - t0 <= 601 * SEC_CYC))
        apb(1'b1, ADDR_CTRL, 32'h00000000);
        wait_for(power_awake, 1'b0, 40 * SEC_CYC);
    endtask : t_sched
    // Topside and sensor wakes, topside timer length
    task automatic t_wake();
        HOST.talk_topside();
        t0 = cyc;
        wait_for(power_awake, 1'b1, 3);
        `CHK("ts_wake", 1'b1, power_awake)
        wait_for(power_awake, 1'b0, 35 * SEC_CYC);
        `CHK("ts_time", 1'b1, (cyc - t0 >= 29 * SEC_CYC && cyc - t0 <= 31 * SEC_CYC))
        @(posedge mclk);
        sensor_insert <= 1'b1;
        @(posedge mclk);
        sensor_insert <= 1'b0;
        wait_for(power_awake, 1'b1, 3);
        `CHK("sensor_wake", 1'b1, power_awake)
        `CHK("sensor_wl", 1'b0, wl_enable)
        wait_for(power_awake, 1'b0, 35 * SEC_CYC);
    endtask : t_wake
    // Magnet swipe wakes, enables wireless, one event per swipe
    task automatic t_mag();
        apb(1'b1, ADDR_IRQ_CLR, 32'h0000001F);
        apb(1'b1, ADDR_IRQ_EN, 32'h00000004);
        HOST.mag_on();
        wait_for(power_awake, 1'b1, 40);
        `CHK("mag_wl", 1'b1, wl_enable)
        `CHK("mag_irq", 1'b1, irq)
        apb(1'b1, ADDR_IRQ_CLR, 32'h00000004);
        repeat (20) @(negedge mclk);
        `CHK("mag_once", 1'b0, irq)
        HOST.mag_off();
    endtask : t_mag
    // Host wireless request wakes from sleep; wireless traffic restarts its timer
    task automatic t_host();
        wait_for(power_awake, 1'b0, 310 * SEC_CYC);
        apb(1'b1, ADDR_CTRL, 32'h00000008);
        wait_for(power_awake, 1'b1, 3);
        `CHK("host_wl", 1'b1, wl_enable)
        repeat (100 * SEC_CYC) @(negedge mclk);
        HOST.talk_wireless();
        t0 = cyc;
        wait_for(power_awake, 1'b0, 310 * SEC_CYC);
        `CHK("wl_restart", 1'b1, (cyc - t0 >= 299 * SEC_CYC && cyc - t0 <= 302 * SEC_CYC))
    endtask : t_host
    ////////////////////////////////////////////////////////////
    // Main sequence, with a power cycle at the end
    initial begin
        resetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {sensor_insert, fault, sh_sync} = '0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        t0 = cyc;
        t_reset();
        t_leds();
        t_modes();
        t_sleep();
        t_sched();
        t_wake();
        t_mag();
        t_host();
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        `CHK("pc_awake", 1'b1, power_awake)
        `CHK("pc_wl", 1'b1, wl_enable)
        test_done();
    end
endmodule : sonde_power_state_led_ctrl_test
`default_nettype wire
